// ===== design/pri_intc.sv
// Notes on behaviour
// RULE1: Arbitrate peripheral sources and four processor traps
// RULE2: Flags set by sources, cleared by software
// RULE3: Flags set regardless of enable bits
// RULE4: Software clears stale flag before enabling
// RULE5: Only enabled sources are forwarded
// RULE6: Priority level stored per source centrally
// RULE7: Levels 1 lowest to 7 highest
// RULE8: Level zero source is never serviced
// RULE9: Level bit 3 control, bits 2-0 status
// RULE10: Nesting disable blocks new interrupts while servicing
// RULE11: Nesting disable makes level bits read-only
// RULE12: Timed disable masks levels six and below
// RULE13: Control registers hold traps, external, table
// RULE14: Program counter loaded through vector multiplexer
// RULE15: Primary table vectors in 0x04 to 0xFE
// RULE16: Fetch from vector space raises address error
// RULE17: Jump into vector space raises address error
// RULE18: Trigger options live in the peripherals; external pin polarity is held here in ext_pol_r
// RULE19: Three-bit field per nibble, top reads zero
// RULE20: Equal levels resolved by lowest source number
// RULE21: Traps use fixed levels eight and above
// RULE22: Level seven masks maskables, traps still taken
// RULE23: Forward only above current CPU level
// RULE24: Alternate table select redirects vector fetch
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module pri_intc #(
  parameter int ADDR_W = 12
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request sources
  input wire logic [pri_pkg::NUM_SLOTS-1:0] src_event,
  input wire logic [pri_pkg::NUM_EXT-1:0] ext_pin,
  input wire logic [pri_pkg::NUM_TRAPS-1:0] trap_event,
  // Core request handshake
  output logic irq_req,
  output logic [5:0] irq_vec,
  output logic [3:0] irq_lvl,
  input wire logic irq_ack,
  input wire logic core_ret,
  input wire logic [3:0] core_ret_lvl,
  output logic [3:0] cpu_priority_level,
  // Core execution monitor
  input wire logic instr_retire,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_addr,
  input wire logic jump_valid,
  input wire logic [23:0] jump_addr,
  // Program memory vector read and program counter mux
  output logic pm_rd,
  output logic [23:0] pm_addr,
  input wire logic [23:0] pm_rdata,
  input wire logic [23:0] pc_seq,
  output logic [23:0] pc_next,
  output logic pc_load
);

  // Register state
  logic [15:0] request_flags_r [pri_pkg::NUM_FLAG_REGS]; // Sticky request flags
  logic [15:0] source_enables_r [pri_pkg::NUM_FLAG_REGS]; // Per-source enables
  logic [2:0] prio_r [pri_pkg::NUM_SLOTS]; // Per-source priority field
  logic nest_dis_r; // Nesting disable control
  logic [pri_pkg::NUM_TRAPS-1:0] trap_flags_r; // Pending trap status
  logic alt_sel_r; // Alternate table select
  logic [pri_pkg::NUM_EXT-1:0] ext_pol_r; // 1 = rising edge, 0 = falling
  logic [3:0] cpu_lvl_r; // Current CPU priority level
  logic [pri_pkg::TDIS_W-1:0] tdis_cnt_r; // Timed disable instruction count
  logic [3:0] depth_r; // Interrupts currently in service
  pri_pkg::pri_state_t st_r; // Vector fetch state
  logic [31:0] prdata_r;
  logic irq_req_r;
  logic [5:0] irq_vec_r;
  logic [3:0] irq_lvl_r;
  logic pm_rd_r;
  logic [23:0] pm_addr_r;
  logic [23:0] pc_next_r;
  logic pc_load_r;

  // External pin synchronisers; the second and third stages feed the edge logic
  logic [pri_pkg::NUM_EXT-1:0] ext_s1_r, ext_s2_r, ext_s3_r;

  // APB decode
  wire [4:0] idx = paddr[6:2];
  wire idx_ok = (paddr[ADDR_W-1:7] == '0) && (idx < 5'(pri_pkg::NUM_WORDS));
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr_en = access && pwrite && idx_ok;
  wire [15:0] wd = pwdata[15:0];
  wire tdis_act = (tdis_cnt_r != '0);
  wire lvl_wr_ok = !nest_dis_r; // RULE11
  wire wr_status = wr_en && (idx == pri_pkg::IDX_CORE_STATUS) && lvl_wr_ok;
  wire wr_control = wr_en && (idx == pri_pkg::IDX_CORE_CONTROL) && lvl_wr_ok;

  // Zero-wait slave; unmapped words answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !idx_ok;

  // Synchroniser chain and edge events, polarity chosen per pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      ext_s3_r <= '0;
    end else begin
      ext_s1_r <= ext_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  wire [pri_pkg::NUM_EXT-1:0] ext_edge =
    (ext_s2_r & ~ext_s3_r & ext_pol_r) | (~ext_s2_r & ext_s3_r & ~ext_pol_r);

  // Merge pin edges into the natural-order slot positions
  logic [pri_pkg::NUM_SLOTS-1:0] ext_slot;
  always_comb begin
    ext_slot = '0;
    ext_slot[pri_pkg::EXT_SLOT0] = ext_edge[0];
    ext_slot[pri_pkg::EXT_SLOT1] = ext_edge[1];
    ext_slot[pri_pkg::EXT_SLOT2] = ext_edge[2];
  end
  // Peripherals pick their own trigger style; pin levels arrive raw and are edge-detected here per ext_pol_r
  wire [pri_pkg::NUM_SLOTS-1:0] set_evt = src_event | ext_slot; // RULE18

  // Address error detection on the core's fetch and jump paths
  wire fetch_in_vs = fetch_valid && (fetch_addr >= pri_pkg::VSPACE_LO) &&
    (fetch_addr <= pri_pkg::VSPACE_HI); // RULE16
  wire jump_in_vs = jump_valid && (jump_addr >= pri_pkg::VSPACE_LO) &&
    (jump_addr <= pri_pkg::VSPACE_HI); // RULE17
  logic [pri_pkg::NUM_TRAPS-1:0] trap_set;
  always_comb begin
    trap_set = trap_event;
    trap_set[pri_pkg::TRAP_ADDR_ERR] = trap_event[pri_pkg::TRAP_ADDR_ERR] ||
      fetch_in_vs || jump_in_vs;
  end

  // Flag and enable words; a hardware set beats a same-cycle clear
  genvar k;
  generate
    for (k = 0; k < pri_pkg::NUM_FLAG_REGS; k++) begin : g_words
      wire wr_flag = wr_en && (idx == pri_pkg::IDX_FLAGS + 5'(k));
      wire wr_ena = wr_en && (idx == pri_pkg::IDX_ENABLES + 5'(k));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          request_flags_r[k] <= '0;
          source_enables_r[k] <= '0;
        end else begin
          request_flags_r[k] <= (wr_flag ? wd : request_flags_r[k]) |
            set_evt[16*k +: 16]; // RULE2 RULE3
          if (wr_ena) begin
            source_enables_r[k] <= wd;
          end
        end
      end
    end
  endgenerate

  // Priority fields, four per word, low three bits of each nibble
  genvar s;
  generate
    for (s = 0; s < pri_pkg::NUM_SLOTS; s++) begin : g_prio
      wire wr_p = wr_en && (idx == pri_pkg::IDX_PRIO + 5'(s / 4));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prio_r[s] <= '0;
        end else if (wr_p) begin
          prio_r[s] <= wd[pri_pkg::PRIO_NIB_W*(s%4) +: pri_pkg::PRIO_W]; // RULE6 RULE19
        end
      end
    end
  endgenerate

  // Control words: nesting, trap status, table select, pin polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nest_dis_r <= 1'b0;
      trap_flags_r <= '0;
      alt_sel_r <= 1'b0;
      ext_pol_r <= '1;
    end else begin
      if (wr_en && idx == pri_pkg::IDX_CTRL_FIRST) begin
        nest_dis_r <= wd[pri_pkg::NEST_DIS_BIT];
      end
      // Trap status: software write, hardware set wins
      trap_flags_r <= ((wr_en && idx == pri_pkg::IDX_CTRL_FIRST) ?
        wd[pri_pkg::NUM_TRAPS-1:0] : trap_flags_r) | trap_set; // RULE13
      if (wr_en && idx == pri_pkg::IDX_CTRL_SECOND) begin
        alt_sel_r <= wd[pri_pkg::ALT_SEL_BIT]; // RULE13
        ext_pol_r <= wd[pri_pkg::NUM_EXT-1:0];
      end
    end
  end

  // Timed disable: load a count, step down on each retired instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdis_cnt_r <= '0;
    end else if (wr_en && idx == pri_pkg::IDX_TDIS_COUNT) begin
      tdis_cnt_r <= wd[pri_pkg::TDIS_W-1:0];
    end else if (instr_retire && tdis_act) begin
      tdis_cnt_r <= tdis_cnt_r - 1'b1; // RULE12
    end
  end

  // Effective threshold: timed disable raises the floor to six
  wire [3:0] thr = (tdis_act && cpu_lvl_r < pri_pkg::LVL_TDIS_CEIL) ?
    pri_pkg::LVL_TDIS_CEIL : cpu_lvl_r; // RULE12
  wire nest_block = nest_dis_r && (depth_r != '0); // RULE10

  // Arbitration; maskable sources first, then traps override them.
  // Scanning down with >= leaves the lowest number on a tie.
  logic win_found;
  logic [3:0] win_lvl;
  logic [5:0] win_vec;
  always_comb begin
    logic [15:0] fl;
    logic [15:0] en;
    logic elig;
    fl = '0;
    en = '0;
    elig = 1'b0;
    win_found = 1'b0;
    win_lvl = '0;
    win_vec = '0;
    for (int i = pri_pkg::NUM_SLOTS - 1; i >= 0; i--) begin // RULE1
      fl = request_flags_r[i / 16];
      en = source_enables_r[i / 16];
      elig = fl[i % 16] && en[i % 16] && // RULE5
        (prio_r[i] != '0) && // RULE8
        ({1'b0, prio_r[i]} > thr) && !nest_block; // RULE7 RULE23 RULE22
      if (elig && {1'b0, prio_r[i]} >= win_lvl) begin // RULE20
        win_found = 1'b1;
        win_lvl = {1'b0, prio_r[i]};
        win_vec = pri_pkg::VEC_SLOT_BASE + 6'(i);
      end
    end
    // Traps sit at fixed levels above every maskable one
    for (int t = 0; t < pri_pkg::NUM_TRAPS; t++) begin
      if (trap_flags_r[t] && (pri_pkg::TRAP_LVL_BASE + 4'(t)) > cpu_lvl_r) begin // RULE21
        win_found = 1'b1;
        win_lvl = pri_pkg::TRAP_LVL_BASE + 4'(t);
        win_vec = pri_pkg::VEC_TRAP_BASE + 6'(t);
      end
    end
  end

  // Vector address from the selected table, two words per vector
  wire [23:0] tbl_base = alt_sel_r ? pri_pkg::ALTERNATE_TABLE_BASE :
    pri_pkg::PRIMARY_TABLE_BASE; // RULE24 RULE15
  wire [23:0] vec_addr = tbl_base + {17'h0, irq_vec_r, 1'b0};
  wire take = (st_r == pri_pkg::PRI_IDLE) && irq_ack && irq_req_r;

  // Request presented to the core, held quiet during a fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_r <= 1'b0;
      irq_vec_r <= '0;
      irq_lvl_r <= '0;
    end else begin
      irq_req_r <= win_found && (st_r == pri_pkg::PRI_IDLE) && !irq_ack;
      irq_vec_r <= win_vec;
      irq_lvl_r <= win_lvl;
    end
  end

  // CPU level: taking, returning, then software in that order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_lvl_r <= pri_pkg::LVL_RESET;
    end else if (take) begin
      cpu_lvl_r <= irq_lvl_r;
    end else if (core_ret) begin
      cpu_lvl_r <= core_ret_lvl;
    end else if (wr_status) begin
      cpu_lvl_r[2:0] <= wd[2:0]; // RULE9
    end else if (wr_control) begin
      cpu_lvl_r[pri_pkg::LVL_HI_BIT] <= wd[pri_pkg::LVL_HI_BIT]; // RULE9
    end
  end

  // Service depth for the nesting guard
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_r <= '0;
    end else if (take && !core_ret) begin
      depth_r <= depth_r + 1'b1;
    end else if (core_ret && !take && depth_r != '0) begin
      depth_r <= depth_r - 1'b1;
    end
  end

  // Vector fetch: read program memory, then steer its word into the PC
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= pri_pkg::PRI_IDLE;
      pm_rd_r <= 1'b0;
      pm_addr_r <= '0;
      pc_next_r <= '0;
      pc_load_r <= 1'b0;
    end else begin
      pm_rd_r <= take;
      pc_load_r <= (st_r == pri_pkg::PRI_FETCH);
      // 24-bit mux at the program counter input
      pc_next_r <= (st_r == pri_pkg::PRI_FETCH) ? pm_rdata : pc_seq; // RULE14
      unique case (st_r)
        pri_pkg::PRI_IDLE: begin
          if (take) begin
            pm_addr_r <= vec_addr;
            st_r <= pri_pkg::PRI_FETCH;
          end
        end
        pri_pkg::PRI_FETCH: begin
          st_r <= pri_pkg::PRI_IDLE;
        end
      endcase
    end
  end

  // Readable words
  logic [31:0] rd_words [pri_pkg::NUM_WORDS];
  generate
    for (k = 0; k < pri_pkg::NUM_FLAG_REGS; k++) begin : g_rd_fl
      assign rd_words[k] = {16'h0, request_flags_r[k]};
      assign rd_words[k + 3] = {16'h0, source_enables_r[k]};
    end
    for (k = 0; k < pri_pkg::NUM_PRIO_REGS; k++) begin : g_rd_pr
      assign rd_words[k + 6] = {16'h0, 1'b0, prio_r[4*k+3], 1'b0, prio_r[4*k+2],
        1'b0, prio_r[4*k+1], 1'b0, prio_r[4*k]}; // RULE19
    end
  endgenerate
  assign rd_words[18] = {16'h0, nest_dis_r, 11'h0, trap_flags_r};
  assign rd_words[19] = {16'h0, alt_sel_r, tdis_act, 11'h0, ext_pol_r};
  assign rd_words[20] = {29'h0, cpu_lvl_r[2:0]};
  assign rd_words[21] = {28'h0, cpu_lvl_r[pri_pkg::LVL_HI_BIT], 3'h0};
  assign rd_words[22] = {18'h0, tdis_cnt_r};
  assign rd_words[23] = {16'h0, irq_req_r, depth_r, irq_lvl_r, 1'b0, irq_vec_r};
  wire [31:0] rd_sel = idx_ok ? rd_words[idx] : 32'h0000_0000;

  // Read data captured in the setup cycle, valid for the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_sel;
    end
  end

  // Outputs
  assign prdata = prdata_r;
  assign irq_req = irq_req_r;
  assign irq_vec = irq_vec_r;
  assign irq_lvl = irq_lvl_r;
  assign cpu_priority_level = cpu_lvl_r;
  assign pm_rd = pm_rd_r;
  assign pm_addr = pm_addr_r;
  assign pc_next = pc_next_r;
  assign pc_load = pc_load_r;

endmodule

`default_nettype wire

// ===== design/pri_pkg.sv
package pri_pkg;

  // Source and register geometry
  localparam int NUM_SLOTS = 48;
  localparam int NUM_FLAG_REGS = 3;
  localparam int NUM_PRIO_REGS = 12;
  localparam int REG_W = 16;
  localparam int NUM_TRAPS = 4;
  localparam int NUM_EXT = 3;
  localparam int NUM_WORDS = 24;
  localparam int TDIS_W = 14;

  // Word indices; byte address is four times the index
  localparam logic [4:0] IDX_FLAGS = 5'h00;
  localparam logic [4:0] IDX_ENABLES = 5'h03;
  localparam logic [4:0] IDX_PRIO = 5'h06;
  localparam logic [4:0] IDX_CTRL_FIRST = 5'h12;
  localparam logic [4:0] IDX_CTRL_SECOND = 5'h13;
  localparam logic [4:0] IDX_CORE_STATUS = 5'h14;
  localparam logic [4:0] IDX_CORE_CONTROL = 5'h15;
  localparam logic [4:0] IDX_TDIS_COUNT = 5'h16;
  localparam logic [4:0] IDX_ACTIVE = 5'h17;

  // Field positions
  localparam int NEST_DIS_BIT = 15;
  localparam int ALT_SEL_BIT = 15;
  localparam int TDIS_ACT_BIT = 14;
  localparam int LVL_HI_BIT = 3;
  localparam int PRIO_NIB_W = 4;
  localparam int PRIO_W = 3;
  localparam int TRAP_ADDR_ERR = 1;

  // Priority levels
  localparam logic [3:0] LVL_TDIS_CEIL = 4'h6;
  localparam logic [3:0] TRAP_LVL_BASE = 4'hc;
  localparam logic [3:0] LVL_RESET = 4'h0;

  // Vector numbering and tables
  localparam logic [5:0] VEC_SLOT_BASE = 6'h08;
  localparam logic [5:0] VEC_TRAP_BASE = 6'h01;
  localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
  localparam logic [23:0] ALTERNATE_TABLE_BASE = 24'h000084;
  localparam logic [23:0] VSPACE_LO = 24'h000004;
  localparam logic [23:0] VSPACE_HI = 24'h0000fe;

  // External pin slots in natural order
  localparam int EXT_SLOT0 = 0;
  localparam int EXT_SLOT1 = 16;
  localparam int EXT_SLOT2 = 23;

  // Vector fetch sequencer
  typedef enum logic [0:0] {
    PRI_IDLE = 1'b0,
    PRI_FETCH = 1'b1
  } pri_state_t;

endpackage

// ===== bench/pri_intc_props.sv
`timescale 1ns/1ps
`default_nettype none
module pri_intc_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core handshake
  input wire logic irq_req,
  input wire logic [5:0] irq_vec,
  input wire logic [3:0] irq_lvl,
  input wire logic irq_ack,
  input wire logic [3:0] cpu_priority_level,
  // Monitors and vector path
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_addr,
  input wire logic jump_valid,
  input wire logic [23:0] jump_addr,
  input wire logic pm_rd,
  input wire logic [23:0] pm_addr,
  input wire logic [23:0] pm_rdata,
  input wire logic [23:0] pc_next,
  input wire logic pc_load
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Request accepted by the core in this cycle
  logic took;
  logic in_vs;
  logic [23:0] vofs;
  assign took = irq_ack && irq_req;
  // Table offset of the presented vector, two words per entry
  assign vofs = {17'h0, irq_vec, 1'b0};
  // Either monitor points into the vector space
  assign in_vs = (fetch_valid && fetch_addr >= 24'h000004 && fetch_addr <= 24'h0000fe)
    || (jump_valid && jump_addr >= 24'h000004 && jump_addr <= 24'h0000fe);
  chk_take_read: assert property (took |=> pm_rd && !irq_req)
    else $error("vector read missing after acknowledge");
  chk_vec_addr: assert property (took |=> pm_addr == 24'h000004 + $past(vofs) ||
    pm_addr == 24'h000084 + $past(vofs))
    else $error("vector address off table");
  chk_pc_mux: assert property (pm_rd |-> ##1 pc_load && pc_next == $past(pm_rdata))
    else $error("program counter not loaded with vector");
  chk_lvl_taken: assert property (took |=> cpu_priority_level == $past(irq_lvl))
    else $error("level not raised to accepted level");
  // Level must be settled two samples, the request lags it by one register
  chk_above_cpu: assert property (irq_req && irq_vec >= 6'h08 &&
    $stable(cpu_priority_level) && $past(cpu_priority_level, 2) == cpu_priority_level
    |-> irq_lvl > cpu_priority_level && irq_lvl <= 4'h7)
    else $error("maskable request not above cpu level");
  chk_trap_lvl: assert property (irq_req && irq_vec < 6'h08 |-> irq_lvl == irq_vec[3:0] + 4'hb)
    else $error("trap level wrong");
  chk_no_zero: assert property (irq_req |-> irq_lvl != 4'h0)
    else $error("level zero presented");
  chk_vs_trap: assert property (in_vs && cpu_priority_level < 4'hc |-> ##[1:6] irq_req && irq_lvl[3])
    else $error("vector space access without trap");
  // Main scenarios reached
  cover property (took);
  cover property (pc_load);
  cover property (irq_req && irq_vec < 6'h08);
endmodule
bind pri_intc pri_intc_props pri_intc_props_i (.pclk, .presetn, .irq_req, .irq_vec, .irq_lvl,
  .irq_ack, .cpu_priority_level, .fetch_valid, .fetch_addr, .jump_valid, .jump_addr, .pm_rd,
  .pm_addr, .pm_rdata, .pc_next, .pc_load);
`default_nettype wire

// ===== bench/pri_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pri_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request handshake
  input wire logic ack_on,
  input wire logic irq_req,
  output logic irq_ack,
  // Vector memory
  input wire logic pm_rd,
  input wire logic [23:0] pm_addr,
  output logic [23:0] pm_rdata
);
  logic fetching_r;
  // Ack only when no vector fetch is in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      fetching_r <= 1'b0;
    end else begin
      fetching_r <= pm_rd;
      irq_ack <= ack_on && irq_req && !irq_ack && !pm_rd && !fetching_r;
    end
  end
  // Vector word stands while the read strobe is high, as the controller samples it
  // then; inverted otherwise so a sample in the wrong cycle shows up
  assign pm_rdata = pm_rd ? (pm_addr | 24'h100000) : ~(pm_addr | 24'h100000);
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // APB master side
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, errv;
  // Sources; one address feeds both monitors
  logic [47:0] src_event = 48'h0;
  logic [2:0] ext_pin = 3'h0;
  logic instr_retire = 1'b0;
  logic [3:0] trap_event = 4'h0;
  logic fetch_valid = 1'b0;
  logic jump_valid = 1'b0;
  logic [23:0] mon_addr = 24'h0;
  // Core side
  logic core_ret = 1'b0;
  logic ack_on = 1'b0;
  logic irq_req, irq_ack, pm_rd, pc_load;
  logic [5:0] irq_vec;
  logic [3:0] irq_lvl, cpu_priority_level;
  logic [23:0] pm_addr, pm_rdata, pc_next;
  int err_total = 0;
  int tests_run = 0;
  // Restored level and sequential PC are tied off
  pri_intc #(.ADDR_W(12)) pri_intc_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .src_event, .ext_pin, .trap_event, .irq_req,
    .irq_vec, .irq_lvl, .irq_ack, .core_ret, .core_ret_lvl(4'h0), .cpu_priority_level,
    .instr_retire, .fetch_valid, .fetch_addr(mon_addr), .jump_valid, .jump_addr(mon_addr),
    .pm_rd, .pm_addr, .pm_rdata, .pc_seq(24'h0), .pc_next, .pc_load);
  pri_core_model pri_core_model_i (.pclk, .presetn, .ack_on, .irq_req, .irq_ack, .pm_rd,
    .pm_addr, .pm_rdata);
  initial forever #20 pclk = ~pclk;
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One transfer, held until pready; an idle edge follows so strobes never retoggle
  task automatic apb(logic w, logic [11:0] a, logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(logic [11:0] a, logic [15:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(logic [11:0] a, logic [15:0] e, string n);
    apb(1'b0, a, 16'h0);
    cmp(n, {16'h0, e}, rdv);
  endtask
  // Request state once the arbiter has settled
  task automatic irq(logic r, logic [5:0] v);
    repeat (3) @(posedge pclk);
    cmp("irq_req", {31'h0, r}, {31'h0, irq_req});
    if (r) cmp("irq_vec", {26'h0, v}, {26'h0, irq_vec});
  endtask
  task automatic ev(logic [47:0] m);
    src_event <= m;
    @(posedge pclk);
    src_event <= 48'h0;
  endtask
  // Core acks and loads the vector
  task automatic serve;
    ack_on <= 1'b1;
    do @(posedge pclk); while (pc_load !== 1'b1);
    ack_on <= 1'b0;
  endtask
  task automatic mon(logic j, logic [23:0] a, logic [15:0] e);
    mon_addr <= a;
    fetch_valid <= !j;
    jump_valid <= j;
    @(posedge pclk);
    fetch_valid <= 1'b0;
    jump_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    rd(12'h048, e, "ctrl1");
  endtask
  task automatic t_reset;
    rd(12'h000, 16'h0000, "flags0");
    rd(12'h018, 16'h0000, "prio0");
    rd(12'h04c, 16'h0007, "ctrl2");
    apb(1'b0, 12'h060, 16'h0);
    cmp("pslverr", 32'h1, {31'h0, errv});
    $display("test reset done");
  endtask
  task automatic t_flag;
    ev(48'h0100_0000_0020);
    irq(1'b0, 6'h0);
    rd(12'h000, 16'h0020, "flags0");
    rd(12'h008, 16'h0100, "flags2");
    ext_pin <= 3'b010;
    wr(12'h000, 16'h0000);
    rd(12'h000, 16'h0000, "flags0");
    rd(12'h004, 16'h0001, "flags1");
    wr(12'h004, 16'h0000);
    wr(12'h008, 16'h0000);
    // Pin 1 switched to falling edges, then released low
    wr(12'h04c, 16'h0005);
    ext_pin <= 3'b000;
    repeat (3) @(posedge pclk);
    rd(12'h004, 16'h0001, "flags1 fall");
    wr(12'h004, 16'h0000);
    wr(12'h04c, 16'h0007);
    $display("test flags done");
  endtask
  task automatic t_arb;
    wr(12'h018, 16'hffff);
    rd(12'h018, 16'h7777, "prio0");
    wr(12'h018, 16'h0000);
    wr(12'h00c, 16'h0006);
    ev(48'h6);
    irq(1'b0, 6'h0);
    wr(12'h018, 16'h0330);
    irq(1'b1, 6'h09);
    wr(12'h018, 16'h0530);
    irq(1'b1, 6'h0a);
    wr(12'h050, 16'h0005);
    irq(1'b0, 6'h0);
    wr(12'h050, 16'h0004);
    irq(1'b1, 6'h0a);
    wr(12'h050, 16'h0007);
    irq(1'b0, 6'h0);
    wr(12'h050, 16'h0000);
    // Alternate table: entry 10 at 0x84 + 20
    wr(12'h04c, 16'h8007);
    serve;
    cmp("pc_next", 32'h0010_0098, {8'h0, pc_next});
    rd(12'h050, 16'h0005, "status");
    $display("test arbitration done");
  endtask
  task automatic t_nest;
    wr(12'h048, 16'h8000);
    wr(12'h050, 16'h0000);
    rd(12'h050, 16'h0005, "status");
    wr(12'h018, 16'h7530);
    wr(12'h00c, 16'h000e);
    ev(48'h8);
    irq(1'b0, 6'h0);
    core_ret <= 1'b1;
    @(posedge pclk);
    core_ret <= 1'b0;
    irq(1'b1, 6'h0b);
    wr(12'h048, 16'h0000);
    wr(12'h000, 16'h0000);
    $display("test nesting done");
  endtask
  task automatic t_tdis;
    wr(12'h018, 16'h0060);
    wr(12'h058, 16'h0003);
    rd(12'h04c, 16'hc007, "ctrl2");
    ev(48'h2);
    irq(1'b0, 6'h0);
    instr_retire <= 1'b1;
    repeat (3) @(posedge pclk);
    instr_retire <= 1'b0;
    irq(1'b1, 6'h09);
    rd(12'h04c, 16'h8007, "ctrl2");
    wr(12'h00c, 16'h0000);
    wr(12'h000, 16'h0000);
    $display("test timed disable done");
  endtask
  task automatic t_trap;
    wr(12'h050, 16'h0007);
    mon(1'b0, 24'h000010, 16'h0002);
    irq(1'b1, 6'h02);
    cmp("irq_lvl", 32'hd, {28'h0, irq_lvl});
    // Back to the primary table for this vector
    wr(12'h04c, 16'h0007);
    serve;
    cmp("pc_next", 32'h0010_0008, {8'h0, pc_next});
    cmp("cpu level", 32'hd, {28'h0, cpu_priority_level});
    rd(12'h050, 16'h0005, "status");
    rd(12'h054, 16'h0008, "corectl");
    wr(12'h048, 16'h0000);
    mon(1'b1, 24'h0000fe, 16'h0002);
    wr(12'h048, 16'h0000);
    mon(1'b1, 24'h0000ff, 16'h0000);
    mon(1'b0, 24'h000100, 16'h0000);
    // Highest trap still beats the level of a trap in service
    trap_event <= 4'h8;
    @(posedge pclk);
    trap_event <= 4'h0;
    irq(1'b1, 6'h04);
    wr(12'h048, 16'h0000);
    $display("test traps done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_flag;
    t_arb;
    t_nest;
    t_tdis;
    t_trap;
    wrap_up;
  end
  // Hang guard, well above the expected run
  initial begin
    repeat (3000) @(posedge pclk);
    err_total++;
    $display("BAD watchdog expected finish seen timeout");
    wrap_up;
  end
endmodule
`default_nettype wire
